// File: include/bank_defines.svh
`ifndef BANK_DEFINES_SVH
`define BANK_DEFINES_SVH
// ------------------------------
// Address map
// ------------------------------
`define PAGE_ADDR 7'h3F
`define BANKED_LO 7'h2E
`define BANKED_HI 7'h3E
`define EVT_ADDR 7'h2A
`define STAT_ADDR 7'h2B
`define OSC_ADDR 7'h0C
`define OSC_W 6
`define RSVD_BIT 6
`define B0_N 63
`define B1_N 17
// ------------------------------
// Reset values and masks
// ------------------------------
`define DEF_02 8'hB1
`define DEF_0D 8'h01
`define DEF_0F 8'h60
`define DEF_ZERO 8'h00
`define MASK_LO_NIB 8'hF0
`define MASK_FULL 8'hFF
`define EVT_POR 8'h01
// ------------------------------
// Serial frame
// ------------------------------
`define CMD_LAST 5'd7
`define FRAME_LAST 5'd15
`define FRAME_END 5'd16
`endif

// File: include/bank_pkg.sv
package bank_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic sen_n;
  } spi_pins_s;
endpackage : bank_pkg

// File: core/bank_regs.sv
`timescale 1ns/1ps
`include "bank_defines.svh"
module bank_regs
  import bank_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire spi_pins_s spi_pins,
  output logic sdo,
  output logic sdo_oe,
  input wire byte_t status_live,
  input wire logic [6:0] evt_set,
  input wire logic osc_we,
  input wire logic [`OSC_W-1:0] osc_val,
  input wire logic pwr_down,
  output logic page_q,
  output byte_t [`B0_N-1:0] bank0_q,
  output byte_t [`B1_N-1:0] bank1_q
);
  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic byte_t def_val(input int idx);
    case (idx)
      2: def_val = `DEF_02;
      13: def_val = `DEF_0D;
      15: def_val = `DEF_0F;
      default: def_val = `DEF_ZERO;
    endcase
  endfunction : def_val

  typedef byte_t [`B0_N-1:0] bank0_t;

  function automatic bank0_t bank0_defaults();
    bank0_t v;
    for (int i = 0; i < `B0_N; i++) begin
      v[i] = def_val(i);
    end
    return v;
  endfunction : bank0_defaults

  localparam bank0_t BANK0_DEF = bank0_defaults();

  function automatic byte_t impl_mask(input logic [6:0] a);
    if (a == 7'h00 || a == 7'h03 || a == 7'h06 || a == 7'h09) begin
      impl_mask = `MASK_LO_NIB;
    end else begin
      impl_mask = `MASK_FULL;
    end
  endfunction : impl_mask

  // ------------------------------
  // Pin synchroniser
  // ------------------------------
  spi_pins_s sy1_q, sy2_q, sy3_q, flt_q, flt_d;
  always_comb begin
    flt_d = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & flt_q);
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sy1_q <= '{sclk: 1'b0, sdi: 1'b0, sen_n: 1'b1};
      sy2_q <= '{sclk: 1'b0, sdi: 1'b0, sen_n: 1'b1};
      sy3_q <= '{sclk: 1'b0, sdi: 1'b0, sen_n: 1'b1};
      flt_q <= '{sclk: 1'b0, sdi: 1'b0, sen_n: 1'b1};
    end else begin
      sy1_q <= spi_pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      flt_q <= flt_d;
    end
  end

  // ------------------------------
  // Serial frame engine
  // ------------------------------
  logic active, rise, fall, cmd_done, wr_go;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] sh_q, sh_d, addr_q, addr_d, cmd_addr;
  logic rw_q, rw_d, sdo_d, oe_d;
  byte_t out_q, out_d, rd_data, wdata;
  byte_t evt_q, evt_d;
  assign active = !flt_q.sen_n;
  assign rise = active && flt_d.sclk && !flt_q.sclk;
  assign fall = active && !flt_d.sclk && flt_q.sclk;
  assign cmd_done = rise && cnt_q == `CMD_LAST;
  assign cmd_addr = {sh_q[5:0], flt_q.sdi};
  assign wr_go = rise && cnt_q == `FRAME_LAST && !rw_q;
  assign wdata = {sh_q, flt_q.sdi};

  always_comb begin
    rd_data = `DEF_ZERO;
    if (cmd_addr == `PAGE_ADDR) begin
      rd_data = {7'h00, page_q};
    end else if (cmd_addr == `STAT_ADDR) begin
      rd_data = status_live;
    end else if (cmd_addr == `EVT_ADDR) begin
      rd_data = {evt_q[7:1] | evt_set, evt_q[0]};
    end else if (cmd_addr >= `BANKED_LO && cmd_addr <= `BANKED_HI && page_q) begin
      rd_data = bank1_q[5'(cmd_addr - `BANKED_LO)];
    end else if (cmd_addr < `PAGE_ADDR) begin
      rd_data = bank0_q[6'(cmd_addr)] & impl_mask(cmd_addr);
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    rw_d = rw_q;
    out_d = out_q;
    sdo_d = sdo;
    oe_d = active && rw_q && cnt_q > `CMD_LAST && cnt_q < `FRAME_END;
    if (!active) begin
      cnt_d = 5'd0;
      sdo_d = 1'b0;
    end else if (rise && cnt_q < `FRAME_END) begin
      cnt_d = cnt_q + 5'd1;
      sh_d = {sh_q[5:0], flt_q.sdi};
      if (cmd_done) begin
        rw_d = sh_q[6];
        addr_d = cmd_addr;
        out_d = rd_data;
      end
    end else if (fall && rw_q && cnt_q > `CMD_LAST) begin
      sdo_d = out_q[7];
      out_d = {out_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 5'd0;
      sh_q <= 7'h00;
      addr_q <= 7'h00;
      rw_q <= 1'b0;
      out_q <= `DEF_ZERO;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      out_q <= out_d;
      sdo <= sdo_d;
      sdo_oe <= oe_d;
    end
  end

  // ------------------------------
  // Register storage
  // ------------------------------
  byte_t [`B0_N-1:0] bank0_d;
  byte_t [`B1_N-1:0] bank1_d;
  logic page_d, banked, is_status;
  assign banked = addr_q >= `BANKED_LO && addr_q <= `BANKED_HI;
  assign is_status = addr_q == `STAT_ADDR || addr_q == `EVT_ADDR;

  always_comb begin
    bank0_d = bank0_q;
    bank1_d = bank1_q;
    page_d = page_q;
    evt_d = evt_q;
    if (cmd_done && sh_q[6] && cmd_addr == `EVT_ADDR) begin
      evt_d = `DEF_ZERO;
    end
    evt_d[7:1] = evt_d[7:1] | evt_set;
    if (wr_go) begin
      if (addr_q == `PAGE_ADDR) begin
        page_d = wdata[0];
      end else if (is_status) begin
        page_d = page_q;
      end else if (banked && page_q) begin
        bank1_d[5'(addr_q - `BANKED_LO)] = wdata;
      end else if (addr_q < `PAGE_ADDR) begin
        bank0_d[6'(addr_q)] = wdata & impl_mask(addr_q);
      end
    end
    if (osc_we && !pwr_down) begin
      bank0_d[6'(`OSC_ADDR)][`OSC_W-1:0] = osc_val;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank0_q <= BANK0_DEF;
      bank1_q <= '0;
      page_q <= 1'b0;
      evt_q <= `EVT_POR;
    end else begin
      bank0_q <= bank0_d;
      bank1_q <= bank1_d;
      page_q <= page_d;
      evt_q <= evt_d;
    end
  end

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  page_write_a: assert property (wr_go && addr_q == `PAGE_ADDR
      |=> page_q == $past(wdata[0]))
    else $error("page bit not taken from write");

  unbanked_wr_a: assert property (wr_go && addr_q < `BANKED_LO && addr_q != `OSC_ADDR
      && !is_status |=> bank0_q[6'($past(addr_q))] == ($past(wdata) & impl_mask($past(addr_q))))
    else $error("unbanked write lost");

  page_read_a: assert property (cmd_done && cmd_addr == `PAGE_ADDR
      |=> out_q == {7'h00, $past(page_q)})
    else $error("page register read wrong");

  high_wr_drop_a: assert property (wr_go && addr_q > `PAGE_ADDR && !osc_we
      |=> $stable(bank0_q) && $stable(bank1_q) && $stable(page_q))
    else $error("write above the map took effect");

  bank1_keep_a: assert property (wr_go && banked && !page_q |=> $stable(bank1_q))
    else $error("bank 1 changed while page clear");

  bank0_write_a: assert property (wr_go && banked && !page_q
      |=> bank0_q[6'($past(addr_q))] == $past(wdata))
    else $error("bank 0 write lost while page clear");

  bank0_read_a: assert property (cmd_done && !page_q && cmd_addr >= `BANKED_LO
      && cmd_addr <= `BANKED_HI |=> out_q == $past(bank0_q[6'(cmd_addr)]))
    else $error("bank 0 read wrong while page clear");

  bank0_keep_a: assert property (wr_go && banked && page_q
      |=> $stable(bank0_q) || $past(osc_we))
    else $error("bank 0 changed while page set");

  bank1_read_a: assert property (cmd_done && page_q && cmd_addr >= `BANKED_LO
      && cmd_addr <= `BANKED_HI |=> out_q == $past(bank1_q[5'(cmd_addr - `BANKED_LO)]))
    else $error("bank 1 read wrong while page set");

  status_live_a: assert property (cmd_done && cmd_addr == `STAT_ADDR
      |=> out_q == $past(status_live))
    else $error("status read not live");

  status_drop_a: assert property (wr_go && is_status && !osc_we
      |=> $stable(bank0_q) && $stable(bank1_q) && $stable(page_q))
    else $error("status write took effect");

  oe_window_a: assert property (sdo_oe |-> $past(rw_q) && $past(active))
    else $error("sdo driven outside a read");

  oe_drop_a: assert property (!active |=> !sdo_oe)
    else $error("sdo still driven after frame end");

  cmd_latch_a: assert property (cmd_done
      |=> addr_q == $past(cmd_addr) && rw_q == $past(sh_q[6]))
    else $error("command byte not latched");

  sdo_shift_a: assert property (fall && rw_q && cnt_q > `CMD_LAST
      |=> sdo == $past(out_q[7]))
    else $error("read bit not shifted out");

  extra_bits_a: assert property (rise && cnt_q == `FRAME_END
      |=> cnt_q == `FRAME_END && $stable(sh_q))
    else $error("bit after frame end taken");

  unimpl_zero_a: assert property (bank0_q[0][3:0] == 4'h0 && bank0_q[3][3:0] == 4'h0
      && bank0_q[6][3:0] == 4'h0 && bank0_q[9][3:0] == 4'h0)
    else $error("unimplemented bits hold ones");

  unimpl_read_a: assert property (cmd_done && cmd_addr == `PAGE_ADDR
      |=> out_q[7:1] == 7'h00)
    else $error("unimplemented page bits read as one");

  high_rd_zero_a: assert property (cmd_done && cmd_addr > `PAGE_ADDR
      |=> out_q == `DEF_ZERO)
    else $error("read above the map not zero");

  osc_update_a: assert property (osc_we && !pwr_down
      |=> bank0_q[6'(`OSC_ADDR)][`OSC_W-1:0] == $past(osc_val))
    else $error("oscillator range not updated");

  evt_set_wins_a: assert property (cmd_done && sh_q[6] && cmd_addr == `EVT_ADDR
      |=> evt_q[7:1] == $past(evt_set))
    else $error("event lost in clearing read");

  evt_sticky_a: assert property (!(cmd_done && sh_q[6] && cmd_addr == `EVT_ADDR)
      |=> (evt_q & $past(evt_q)) == $past(evt_q))
    else $error("event flag dropped without read");

  pwrdn_hold_a: assert property (pwr_down && !wr_go
      |=> $stable(bank0_q) && $stable(bank1_q))
    else $error("registers moved in power-down");

  osc_pd_block_a: assert property (pwr_down && osc_we && !wr_go
      |=> $stable(bank0_q[6'(`OSC_ADDR)]))
    else $error("oscillator range moved in power-down");

  evt_clear_a: assert property (cmd_done && sh_q[6] && cmd_addr == `EVT_ADDR
      && evt_set == 7'h00 |=> evt_q == `DEF_ZERO ##1 evt_q[0] == 1'b0)
    else $error("event flags not cleared by read");

  rsvd_store_a: assert property (wr_go && addr_q == `OSC_ADDR && !page_q
      |=> bank0_q[6'(`OSC_ADDR)][`RSVD_BIT] == $past(wdata[`RSVD_BIT]))
    else $error("reserved bit not stored");

  // ------------------------------
  // Cover points
  // ------------------------------
  write_frame_c: cover property (wr_go ##[1:40] wr_go);
  page_switch_c: cover property (wr_go && addr_q == `PAGE_ADDR ##[1:400] wr_go && banked);
  read_frame_c: cover property (cmd_done && sh_q[6] ##[1:200] sdo_oe [*8]);
  evt_race_c: cover property (cmd_done && cmd_addr == `EVT_ADDR && evt_set != 7'h00);
  status_read_c: cover property (cmd_done && sh_q[6] && cmd_addr == `STAT_ADDR);
endmodule : bank_regs

// File: bench/spi_host.sv
`timescale 1ns/1ps
// ------------------------------
// Host side of the serial port
// ------------------------------
module spi_host
  import bank_pkg::*;
#(
  parameter int HALF = 8
)
(
  input wire logic clk_sys,
  input wire logic sdo,
  output spi_pins_s spi_pins
);
  initial spi_pins = '{sclk: 1'b0, sdi: 1'b0, sen_n: 1'b1};

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // One 16-bit frame, MSB first, mode 0
  task automatic xfer(input logic [6:0] a, input logic rd, input byte_t wd,
                      output byte_t q);
    logic [15:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    tick(1);
    spi_pins.sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_pins.sdi = f[i];
      tick(HALF);
      if (i < 8) q[i] = sdo;
      spi_pins.sclk = 1'b1;
      tick(HALF);
      spi_pins.sclk = 1'b0;
    end
    spi_pins.sen_n = 1'b1;
    spi_pins.sdi = ~spi_pins.sdi;
    tick(HALF);
  endtask : xfer
endmodule : spi_host

// File: bench/tb_bank_regs.sv
`timescale 1ns/1ps
`include "bank_defines.svh"
module tb_bank_regs;
  import bank_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn;
  logic pwr_down;
  logic osc_we;
  logic [5:0] osc_val;
  logic [6:0] evt_set;
  byte_t status_live;
  spi_pins_s spi_pins;
  logic sdo;
  logic sdo_oe;
  int oe_cyc = 0;
  logic page_q;
  byte_t [`B0_N-1:0] bank0_q;
  byte_t [`B1_N-1:0] bank1_q;
  byte_t q;
  int errors = 0;
  int n_tests = 0;
  // Address, write data, read-back
  logic [22:0] rows [8] = '{{7'h00, 8'hFF, 8'hF0}, {7'h09, 8'hFF, 8'hF0},
    {7'h0E, 8'hA5, 8'hA5}, {7'h2D, 8'h3C, 8'h3C}, {7'h2E, 8'h5A, 8'h5A},
    {7'h0C, 8'h40, 8'h40}, {7'h45, 8'hFF, 8'h00}, {7'h3F, 8'hFF, 8'h01}};

  always #25 clk_sys = ~clk_sys;

  bank_regs u_bank_regs (.clk_sys(clk_sys), .rstn(rstn), .spi_pins(spi_pins), .sdo(sdo),
    .sdo_oe(sdo_oe), .status_live(status_live), .evt_set(evt_set), .osc_we(osc_we),
    .osc_val(osc_val), .pwr_down(pwr_down), .page_q(page_q), .bank0_q(bank0_q),
    .bank1_q(bank1_q));
  spi_host u_spi_host (.clk_sys(clk_sys), .sdo(sdo), .spi_pins(spi_pins));

  // Cycles in which the device drives sdo
  always @(posedge clk_sys) begin
    if (sdo_oe === 1'b1) begin
      oe_cyc <= oe_cyc + 1;
    end
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(input byte_t got, input byte_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input byte_t d);
    int c0;
    c0 = oe_cyc;
    u_spi_host.xfer(a, 1'b0, d, q);
    chk(8'(oe_cyc - c0), 8'h00);
  endtask : wr

  // Read frame drives sdo for 8 sclk periods of 16 clocks
  task automatic rd(input logic [6:0] a, input byte_t exp);
    int c0;
    c0 = oe_cyc;
    u_spi_host.xfer(a, 1'b1, 8'h00, q);
    chk(q, exp);
    chk(8'(oe_cyc - c0), 8'h80);
  endtask : rd

  task automatic hw(input logic [6:0] e, input logic [5:0] v);
    u_spi_host.tick(1);
    evt_set = e;
    osc_we = (e == 7'h00);
    osc_val = v;
    u_spi_host.tick(1);
    evt_set = 7'h00;
    osc_we = 1'b0;
  endtask : hw

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    rstn = 1'b0;
    pwr_down = 1'b0;
    osc_we = 1'b0;
    osc_val = 6'h00;
    evt_set = 7'h00;
    status_live = 8'h00;
    u_spi_host.tick(16);
    rstn = 1'b1;
    u_spi_host.tick(5);
    foreach (rows[i]) begin
      wr(rows[i][22:16], rows[i][15:8]);
      rd(rows[i][22:16], rows[i][7:0]);
    end
    $display("test rows done");
    wr(7'h2E, 8'h77);
    rd(7'h2E, 8'h77);
    chk(bank0_q[46], 8'h5A);
    wr(7'h3F, 8'h00);
    rd(7'h2E, 8'h5A);
    chk(bank1_q[0], 8'h77);
    $display("test banks done");
    status_live = 8'h3C;
    wr(7'h2B, 8'hFF);
    rd(7'h2B, 8'h3C);
    status_live = 8'hC3;
    rd(7'h2B, 8'hC3);
    $display("test status done");
    hw(7'h00, 6'h15);
    rd(7'h0C, 8'h55);
    pwr_down = 1'b1;
    hw(7'h00, 6'h2A);
    rd(7'h0C, 8'h55);
    chk(bank0_q[14], 8'hA5);
    pwr_down = 1'b0;
    hw(7'h04, 6'h00);
    rd(7'h2A, 8'h09);
    $display("test hardware done");
    rstn = 1'b0;
    u_spi_host.tick(16);
    chk({6'h00, sdo, sdo_oe}, 8'h00);
    rstn = 1'b1;
    u_spi_host.tick(5);
    chk(bank0_q[2], 8'hB1);
    chk(bank0_q[13], 8'h01);
    chk(bank0_q[15], 8'h60);
    chk({7'h00, page_q}, 8'h00);
    chk(bank1_q[0], 8'h00);
    rd(7'h2A, 8'h01);
    $display("test reset done");
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    $display("FAIL %0t timeout", $time);
    summarize();
  end
endmodule : tb_bank_regs
